// file: design/amp_fault_pkg.sv
// Shared constants for the amplifier fault monitor
package amp_fault_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int AXES          = 8;
    localparam int HALL_W        = 3;
    localparam int PAIRS         = 4;
    localparam int GROUPS        = 2;
    localparam int GROUP_AXES    = 4;
    localparam int STATUS_W      = 8;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [5:0] QUERY_IDX_OFS  = 6'h00;
    localparam logic [5:0] QUERY_DATA_OFS = 6'h04;
    localparam logic [5:0] HALL_STATE_OFS = 6'h08;
    localparam logic [5:0] CTRL_OFS       = 6'h0C;
    localparam logic [5:0] CMD_OFS        = 6'h10;
    localparam logic [5:0] STATE_OFS      = 6'h14;

    // ********************************************************
    // Field positions
    // ********************************************************
    // Control register
    localparam int CTRL_OOE_LSB    = 0;
    localparam int CTRL_HANDLER    = 8;
    localparam int CTRL_RUNNING    = 9;
    localparam int CTRL_NEW_REV    = 10;
    localparam int CTRL_RELAY_OPT  = 11;
    // Command register, write one to act
    localparam int CMD_SERVO_HERE  = 0;
    localparam int CMD_MOTOR_OFF   = 1;
    localparam int CMD_CTRL_RESET  = 2;
    // Index-0 status word
    localparam int ST0_OVER_CUR    = 0;
    localparam int ST0_OVER_VOLT   = 1;
    localparam int ST0_OT_LOW      = 2;
    localparam int ST0_UNDER_VOLT  = 3;
    localparam int ST0_OT_HIGH     = 6;
    // State register
    localparam int STATE_MOTOR_OFF = 8;
    localparam int STATE_OC_LATCH  = 9;

    // ********************************************************
    // Values
    // ********************************************************
    localparam logic [STATUS_W-1:0] LOCKOUT_CODE = 8'h03;
    localparam logic [11:0]         CTRL_RESET   = 12'h000;
    localparam logic [1:0]          QIDX_RESET   = 2'h0;
    localparam logic [HALL_W-1:0]   HALL_ZEROS   = 3'h0;
    localparam logic [HALL_W-1:0]   HALL_ONES    = 3'h7;

endpackage

// file: design/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync
    import amp_fault_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         arst_n_in,
    // Pins and filtered result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    // A bit moves only once stages two and three agree
    assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end
        else
        begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;

endmodule

// file: design/amp_fault_monitor.sv
// Amplifier fault supervision with Avalon-MM register access
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module amp_fault_monitor
    import amp_fault_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   arst_n_in,
    // Avalon-MM slave
    input  wire logic [5:0]             avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    // Sensor and comparator pins
    input  wire logic [AXES*HALL_W-1:0] hall_in,
    input  wire logic                   supply_below_12v_in,
    input  wire logic                   supply_above_92v_in,
    input  wire logic                   supply_below_90v_in,
    input  wire logic [PAIRS-1:0]       pair_over_20a_in,
    input  wire logic [GROUPS-1:0]      heat_over_80c_in,
    input  wire logic [GROUPS-1:0]      heat_over_100c_in,
    input  wire logic [AXES-1:0]        cont_current_excess_in,
    input  wire logic                   emergency_lockout_input_in,
    // Amplifier controls
    output logic      [AXES-1:0]        amp_enable_out,
    output logic                        motor_off_out,
    output logic                        relay_open_out,
    output logic                        amp_fault_handler_out
);

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    localparam int PIN_W = AXES*HALL_W + 3 + PAIRS + 2*GROUPS + AXES + 1;

    logic [PIN_W-1:0]         pins_raw;
    logic [PIN_W-1:0]         pins_s;
    logic [AXES*HALL_W-1:0]   hall_s;
    logic                     uv_s;
    logic                     above92_s;
    logic                     below90_s;
    logic [PAIRS-1:0]         oc_s;
    logic [GROUPS-1:0]        ot80_s;
    logic [GROUPS-1:0]        ot100_s;
    logic [AXES-1:0]          cont_s;
    logic                     elo_s;

    assign pins_raw = {hall_in, supply_below_12v_in, supply_above_92v_in,
                       supply_below_90v_in, pair_over_20a_in,
                       heat_over_80c_in, heat_over_100c_in,
                       cont_current_excess_in,
                       emergency_lockout_input_in};

    pin_sync #(.W(PIN_W)) u_sync
    (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .pin_in    (pins_raw),
        .level_out (pins_s)
    );

    assign {hall_s, uv_s, above92_s, below90_s, oc_s, ot80_s, ot100_s,
            cont_s, elo_s} = pins_s;

    // ********************************************************
    // Bus decode
    // ********************************************************
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wr_take;
    logic        sel_qidx;
    logic        sel_qdata;
    logic        sel_hall;
    logic        sel_ctrl;
    logic        sel_cmd;
    logic        sel_state;

    // One wait cycle, then the request is answered
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_take   = avs_write_in & ack_q;
    assign sel_qidx  = (avs_address_in == QUERY_IDX_OFS);
    assign sel_qdata = (avs_address_in == QUERY_DATA_OFS);
    assign sel_hall  = (avs_address_in == HALL_STATE_OFS);
    assign sel_ctrl  = (avs_address_in == CTRL_OFS);
    assign sel_cmd   = (avs_address_in == CMD_OFS);
    assign sel_state = (avs_address_in == STATE_OFS);

    // ********************************************************
    // Software control
    // ********************************************************
    logic [11:0]     ctrl_q;
    logic [1:0]      qidx_q;
    logic            servo_here_cmd;
    logic            motor_off_cmd;
    logic            controller_reset_cmd;
    logic [AXES-1:0] off_on_error;
    logic            handler_present;
    logic            thread0_running;
    logic            new_rev;
    logic            motor_lead_relay_option;

    assign servo_here_cmd = wr_take & sel_cmd
                          & avs_writedata_in[CMD_SERVO_HERE];
    assign motor_off_cmd  = wr_take & sel_cmd
                          & avs_writedata_in[CMD_MOTOR_OFF];
    assign controller_reset_cmd = wr_take & sel_cmd
                                & avs_writedata_in[CMD_CTRL_RESET];

    assign off_on_error    = ctrl_q[CTRL_OOE_LSB +: AXES];
    assign handler_present = ctrl_q[CTRL_HANDLER];
    assign thread0_running = ctrl_q[CTRL_RUNNING];
    assign new_rev         = ctrl_q[CTRL_NEW_REV];
    assign motor_lead_relay_option = ctrl_q[CTRL_RELAY_OPT];

    // ********************************************************
    // Fault detection
    // ********************************************************
    logic [AXES-1:0]   hall_err;
    logic [AXES-1:0]   hall_off_q;
    logic [AXES-1:0]   hall_off_d;
    logic              ov_q;
    logic              ov_d;
    logic              oc_q;
    logic              oc_d;
    logic              oc_now;
    logic [GROUPS-1:0] ot_lat_q;
    logic [GROUPS-1:0] ot_lat_d;
    logic [GROUPS-1:0] ot_now;
    logic [GROUPS-1:0] ot_flag;
    logic              elo_q;
    logic              elo_d;
    logic              elo_mo_q;
    logic              elo_mo_d;
    logic              mo_q;
    logic              mo_d;

    genvar a;
    generate
        for (a = 0; a < AXES; a = a + 1)
        begin : g_hall
            logic [HALL_W-1:0] st;
            assign st = hall_s[a*HALL_W +: HALL_W];
            assign hall_err[a] = (st == HALL_ZEROS) || (st == HALL_ONES);
            // Disable is held until servo-here so a flickering sensor
            // cannot chatter the bridge on and off
            assign hall_off_d[a] = (hall_err[a] & off_on_error[a])
                | (hall_off_q[a] & ~servo_here_cmd & ~controller_reset_cmd);
        end
    endgenerate

    // Hysteresis between 92 V and 90 V; never latched beyond that
    assign ov_d = above92_s
                | (ov_q & ~below90_s & ~controller_reset_cmd);

    assign oc_now = |oc_s;
    // Set wins over clear: servo-here only releases a cleared fault
    assign oc_d = oc_now | (oc_q & ~servo_here_cmd
                & ~controller_reset_cmd);

    assign ot_now = new_rev ? ot80_s : ot100_s;
    assign ot_lat_d = new_rev ? (ot80_s | (ot_lat_q & ~{GROUPS{
                      servo_here_cmd | controller_reset_cmd}}))
                    : '0;
    assign ot_flag = ot_now | ot_lat_q;

    // Lockout recovery needs motor-off first, then servo-here
    assign elo_mo_d = elo_q & ~controller_reset_cmd
                    & (elo_mo_q | motor_off_cmd);
    assign elo_d = elo_s | (elo_q & ~controller_reset_cmd
                 & ~(servo_here_cmd & elo_mo_q));
    assign mo_d = elo_d | motor_off_cmd
                | (mo_q & ~servo_here_cmd & ~controller_reset_cmd);

    // ********************************************************
    // Status words
    // ********************************************************
    logic [STATUS_W-1:0] st0;
    logic [STATUS_W-1:0] st1;
    logic [STATUS_W-1:0] st2;
    logic [STATUS_W-1:0] st3;
    logic [STATUS_W-1:0] query_word;

    always_comb
    begin
        st0 = '0;
        st0[ST0_OVER_CUR]   = oc_q;
        st0[ST0_OVER_VOLT]  = ov_q;
        st0[ST0_OT_LOW]     = ot_flag[0];
        st0[ST0_OT_HIGH]    = ot_flag[1];
        st0[ST0_UNDER_VOLT] = uv_s;
    end

    assign st1 = hall_err[STATUS_W-1:0];
    assign st2 = cont_s[STATUS_W-1:0];
    assign st3 = elo_q ? LOCKOUT_CODE : '0;

    // Pure selection; reading alters no state
    assign query_word = (qidx_q == 2'h0) ? st0 :
                        (qidx_q == 2'h1) ? st1 :
                        (qidx_q == 2'h2) ? st2 : st3;

    // ********************************************************
    // Amplifier enables and motor-off
    // ********************************************************
    logic [AXES-1:0] en_q;
    logic [AXES-1:0] en_d;
    logic            common_off;

    assign common_off = uv_s | ov_q | oc_q | mo_q;

    generate
        for (a = 0; a < AXES; a = a + 1)
        begin : g_en
            assign en_d[a] = ~(common_off | hall_off_q[a]
                           | ot_flag[a/GROUP_AXES]);
        end
    endgenerate

    assign amp_enable_out = en_q;
    assign motor_off_out  = mo_q;

    // ********************************************************
    // Fault handler dispatch
    // ********************************************************
    logic            uv_prev_q;
    logic [AXES-1:0] hall_prev_q;
    logic [GROUPS-1:0] ot_prev_q;
    logic            elo_prev_q;
    logic            new_fault;
    logic            handler_q;
    logic            relay_q;

    // Rising edges only; over-voltage and over-current are left out
    // Low supply is not remembered until a handler runs, so power-up fires
    assign new_fault = (uv_s & ~uv_prev_q)
                     | (|(hall_err & ~hall_prev_q))
                     | (|(ot_flag & ~ot_prev_q))
                     | (elo_s & ~elo_prev_q);

    assign amp_fault_handler_out = handler_q;
    assign relay_open_out        = relay_q;

    // ********************************************************
    // Read data
    // ********************************************************
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (sel_qidx)
            rdata_d[1:0] = qidx_q;
        else if (sel_qdata)
            rdata_d[STATUS_W-1:0] = query_word;
        else if (sel_hall)
            rdata_d[AXES*HALL_W-1:0] = hall_s;
        else if (sel_ctrl)
            rdata_d[11:0] = ctrl_q;
        else if (sel_state)
        begin
            rdata_d[AXES-1:0]        = en_q;
            rdata_d[STATE_MOTOR_OFF] = mo_q;
            rdata_d[STATE_OC_LATCH]  = oc_q;
        end
    end

    assign avs_readdata_out = rdata_q;

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ctrl_q  <= CTRL_RESET;
            qidx_q  <= QIDX_RESET;
        end
        else
        begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
            if (avs_read_in & ~ack_q)
                rdata_q <= rdata_d;
            if (wr_take & sel_ctrl)
                ctrl_q <= avs_writedata_in[11:0];
            if (wr_take & sel_qidx)
                qidx_q <= avs_writedata_in[1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            hall_off_q <= '0;
            ov_q       <= 1'b0;
            oc_q       <= 1'b0;
            ot_lat_q   <= '0;
            elo_q      <= 1'b0;
            elo_mo_q   <= 1'b0;
            mo_q       <= 1'b0;
            en_q       <= '0;
        end
        else
        begin
            hall_off_q <= hall_off_d;
            ov_q       <= ov_d;
            oc_q       <= oc_d;
            ot_lat_q   <= ot_lat_d;
            elo_q      <= elo_d;
            elo_mo_q   <= elo_mo_d;
            mo_q       <= mo_d;
            en_q       <= en_d;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            uv_prev_q   <= 1'b0;
            hall_prev_q <= '0;
            ot_prev_q   <= '0;
            elo_prev_q  <= 1'b0;
            handler_q   <= 1'b0;
            relay_q     <= 1'b0;
        end
        else
        begin
            // A controller reset forgets history so live faults re-fire
            uv_prev_q   <= uv_s & handler_present & thread0_running
                         & ~controller_reset_cmd;
            hall_prev_q <= hall_err & ~{AXES{controller_reset_cmd}};
            ot_prev_q   <= ot_flag & ~{GROUPS{controller_reset_cmd}};
            elo_prev_q  <= elo_s & ~controller_reset_cmd;
            handler_q   <= new_fault & handler_present
                         & thread0_running;
            relay_q     <= motor_lead_relay_option & mo_q;
        end
    end

endmodule

// file: tb/amp_fault_properties.sv
// Port timing properties of the amplifier fault monitor
`timescale 1ns/10ps
module amp_fault_properties
    import amp_fault_pkg::*;
(
    // ****
    // Watched ports
    // ****
    input wire logic             mclk_in,
    input wire logic             arst_n_in,
    input wire logic             avs_read_in,
    input wire logic             avs_write_in,
    input wire logic             avs_waitrequest_out,
    input wire logic             supply_below_12v_in,
    input wire logic             supply_above_92v_in,
    input wire logic [PAIRS-1:0] pair_over_20a_in,
    input wire logic             emergency_lockout_input_in,
    input wire logic [AXES-1:0]  amp_enable_out,
    input wire logic             motor_off_out,
    input wire logic             relay_open_out,
    input wire logic             amp_fault_handler_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence bus_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence oc_held;
        (|pair_over_20a_in) [*8];
    endsequence
    sequence moff_held;
        motor_off_out [*2];
    endsequence

    wait_one_a: assert property (bus_wait |=> !avs_waitrequest_out)
        else $error("bus wait longer than one cycle");
    oc_off_a: assert property (oc_held |-> amp_enable_out == 8'h00)
        else $error("enables stay on under over-current");
    uv_off_a: assert property (supply_below_12v_in [*8] |->
        amp_enable_out == 8'h00)
        else $error("enables stay on under low supply");
    ov_off_a: assert property (supply_above_92v_in [*8] |->
        amp_enable_out == 8'h00)
        else $error("enables stay on under high supply");
    elo_off_a: assert property (emergency_lockout_input_in [*8] |->
        motor_off_out && amp_enable_out == 8'h00)
        else $error("lockout did not force motor-off");
    moff_en_a: assert property (moff_held |-> amp_enable_out == 8'h00)
        else $error("enable high in motor-off state");
    relay_a: assert property (relay_open_out |->
        motor_off_out || $past(motor_off_out))
        else $error("relay open outside motor-off");
    pulse_one_a: assert property (amp_fault_handler_out |=>
        !amp_fault_handler_out)
        else $error("handler request longer than one cycle");
endmodule

bind amp_fault_monitor amp_fault_properties i_props (
    .mclk_in, .arst_n_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .supply_below_12v_in, .supply_above_92v_in,
    .pair_over_20a_in, .emergency_lockout_input_in, .amp_enable_out,
    .motor_off_out, .relay_open_out, .amp_fault_handler_out
);

// file: tb/amp_host_model.sv
// Host side model: command interpreter as register bus master
`timescale 1ns/10ps
module amp_host_model
    import amp_fault_pkg::*;
(
    // Clock
    input  wire logic        mclk_in,
    // Avalon-MM master
    input  wire logic        avs_waitrequest_in,
    output logic      [5:0]  avs_address_out   = 6'h00,
    output logic             avs_read_out      = 1'h0,
    output logic             avs_write_out     = 1'h0,
    output logic      [31:0] avs_writedata_out = 32'h0
);
    // ****
    // Bus cycle, held until the edge that sees waitrequest low
    // ****
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
        avs_address_out   <= a;
        avs_writedata_out <= d;
        avs_read_out      <= !w;
        avs_write_out     <= w;
        do @(posedge mclk_in); while (avs_waitrequest_in !== 1'h0);
        avs_read_out  <= 1'h0;
        avs_write_out <= 1'h0;
        // Idle edge so the next request never lands in this time step
        @(posedge mclk_in);
    endtask

    // Lockout recovery needs motor-off strictly before servo-here
    task automatic recover;
        xfer(1'h1, CMD_OFS, 32'h2);
        xfer(1'h1, CMD_OFS, 32'h1);
    endtask

endmodule

// file: tb/amp_fault_monitor_test.sv
// Self-checking bench for the amplifier fault monitor
`timescale 1ns/10ps
module amp_fault_monitor_test
    import amp_fault_pkg::*;
;
    logic        mclk_in   = 1'h0;
    logic        arst_n_in = 1'h0;
    logic [5:0]  adr;
    logic        rd;
    logic        wr;
    logic        wreq;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [23:0] hall = 24'h249249;
    logic [23:0] hs;
    logic [7:0]  c8;
    logic [7:0]  cce  = 8'h00;
    logic        uv   = 1'h1;
    logic        ov   = 1'h0;
    logic        b90  = 1'h1;
    logic        emergency_lockout_input  = 1'h0;
    logic [3:0]  oc   = 4'h0;
    logic [1:0]  t80  = 2'h0;
    logic [1:0]  t100 = 2'h0;
    logic        hdl;
    logic        rly;
    logic [7:0]  ena;
    logic [31:0] exp_q[$];
    int          errors  = 0;
    int          checked = 0;
    int          pulses  = 0;
    int          cycles  = 0;
    int          a;
    int          g;

    initial forever #5 mclk_in = ~mclk_in;

    amp_fault_monitor i_dut (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .hall_in(hall),
        .supply_below_12v_in(uv), .supply_above_92v_in(ov),
        .supply_below_90v_in(b90), .pair_over_20a_in(oc),
        .heat_over_80c_in(t80), .heat_over_100c_in(t100),
        .cont_current_excess_in(cce), .emergency_lockout_input_in(emergency_lockout_input),
        .amp_enable_out(ena), .motor_off_out(), .relay_open_out(rly),
        .amp_fault_handler_out(hdl)
    );

    amp_host_model i_host (
        .mclk_in(mclk_in), .avs_waitrequest_in(wreq),
        .avs_address_out(adr), .avs_read_out(rd),
        .avs_write_out(wr), .avs_writedata_out(wdat)
    );

    // ****
    // Checking and bookkeeping
    // ****
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read data stand at the edge that sees waitrequest low
    always @(posedge mclk_in)
        if (rd === 1'h1 && wreq === 1'h0)
            cmp(rdat, exp_q.pop_front());

    always @(posedge mclk_in)
    begin
        cycles++;
        if (hdl === 1'h1)
            pulses++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic rd_chk(input logic [5:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'h0, ad, 32'h0);
    endtask

    task automatic wr_reg(input logic [5:0] ad, input logic [31:0] d);
        i_host.xfer(1'h1, ad, d);
    endtask

    task automatic query(input logic [1:0] i, input logic [7:0] e);
        wr_reg(QUERY_IDX_OFS, {30'h0, i});
        rd_chk(QUERY_DATA_OFS, {24'h0, e});
    endtask

    // Pin path is four flops plus the enable register
    task automatic settle;
        repeat (8) @(posedge mclk_in);
    endtask

    task automatic cmd(input logic [2:0] b);
        wr_reg(CMD_OFS, {29'h0, b});
        settle();
    endtask

    // ****
    // Main sequence
    // ****
    initial
    begin
        void'($urandom(83));
        repeat (3) @(posedge mclk_in);
        arst_n_in <= 1'h1;
        @(posedge mclk_in);
        for (int i = 0; i < 8; i++)
            hs[3*i +: 3] = 3'($urandom_range(6, 1));
        hall <= hs;
        rd_chk(CTRL_OFS, {20'h0, CTRL_RESET});
        wr_reg(CTRL_OFS, 32'hFFF);
        uv <= 1'h0;
        rd_chk(CTRL_OFS, 32'hFFF);
        settle();
        cmp(32'(pulses), 32'h1);
        rd_chk(STATE_OFS, 32'hFF);
        cmp({24'h0, ena}, 32'hFF);
        rd_chk(HALL_STATE_OFS, {8'h0, hs});
        a = $urandom_range(7, 0);
        for (int k = 0; k < 2; k++)
        begin
            hall[3*a +: 3] <= k ? HALL_ONES : HALL_ZEROS;
            settle();
            query(2'h1, 8'h1 << a);
            rd_chk(STATE_OFS, 32'hFF & ~(32'h1 << a));
            hall <= hs;
            settle();
            cmd(3'h1);
            rd_chk(STATE_OFS, 32'hFF);
        end
        uv <= 1'h1;
        settle();
        query(2'h0, 8'h08);
        rd_chk(STATE_OFS, 32'h0);
        cmp({24'h0, ena}, 32'h0);
        uv <= 1'h0;
        settle();
        rd_chk(STATE_OFS, 32'hFF);
        ov  <= 1'h1;
        b90 <= 1'h0;
        settle();
        query(2'h0, 8'h02);
        ov <= 1'h0;
        settle();
        rd_chk(STATE_OFS, 32'h0);
        b90 <= 1'h1;
        settle();
        rd_chk(STATE_OFS, 32'hFF);
        wr_reg(CTRL_OFS, 32'h0);
        oc[$urandom_range(3, 0)] <= 1'h1;
        settle();
        query(2'h0, 8'h01);
        oc <= 4'h0;
        settle();
        rd_chk(STATE_OFS, 32'h200);
        cmd(3'h1);
        rd_chk(STATE_OFS, 32'hFF);
        wr_reg(CTRL_OFS, 32'hFFF);
        g = $urandom_range(1, 0);
        t80[g] <= 1'h1;
        settle();
        query(2'h0, g ? 8'h40 : 8'h04);
        t80 <= 2'h0;
        settle();
        rd_chk(STATE_OFS, 32'hFF & ~(32'hF << 4*g));
        cmd(3'h1);
        rd_chk(STATE_OFS, 32'hFF);
        wr_reg(CTRL_OFS, 32'hBFF);
        t100[g] <= 1'h1;
        settle();
        query(2'h0, g ? 8'h40 : 8'h04);
        t100 <= 2'h0;
        settle();
        rd_chk(STATE_OFS, 32'hFF);
        wr_reg(CTRL_OFS, 32'hFFF);
        emergency_lockout_input <= 1'h1;
        settle();
        query(2'h3, LOCKOUT_CODE);
        rd_chk(STATE_OFS, 32'h100);
        cmp({31'h0, rly}, 32'h1);
        emergency_lockout_input <= 1'h0;
        settle();
        cmd(3'h1);
        rd_chk(STATE_OFS, 32'h100);
        query(2'h3, LOCKOUT_CODE);
        i_host.recover();
        settle();
        rd_chk(STATE_OFS, 32'hFF);
        cmp({31'h0, rly}, 32'h0);
        c8 = 8'($urandom);
        cce <= c8;
        settle();
        query(2'h2, c8);
        rd_chk(6'h3C, 32'h0);
        wr_reg(6'h3C, 32'hFFFFFFFF);
        rd_chk(CTRL_OFS, 32'hFFF);
        oc[0] <= 1'h1;
        settle();
        oc <= 4'h0;
        settle();
        cmd(3'h4);
        rd_chk(STATE_OFS, 32'hFF);
        query(2'h0, 8'h00);
        cmp(32'(pulses), 32'h7);
        wrap_up();
    end
endmodule
